// file: hdl/nps_host.sv
// Host sequencer for NAND erase, buffer load and program execute
//
// Function
// [RULE_01] Device erase sets all 64 pages of the block to FFh.
// [RULE_02] Erase needs write enable latch set; host sends write enable first.
// [RULE_03] Erase frame is D8h then a 24-bit page address.
// [RULE_04] Chip select rises right after the last address bit, else erase dropped.
// [RULE_05] Device runs self-timed erase with busy high, status reads allowed.
// [RULE_06] Erase completion clears the write enable latch.
// [RULE_07] Erase into a protected block is not executed.
// [RULE_08] Program is load buffer then execute, one to 2176 bytes.
// [RULE_09] Load opcodes 02h and 84h need write enable latch set.
// [RULE_10] Load carries 16-bit column, low twelve bits used, then data bytes.
// [RULE_11] Chip select stays low for the whole load including data.
// [RULE_12] Device drops data bytes beyond buffer capacity.
// [RULE_13] Normal load fills unwritten bytes with FFh; random load keeps them.
// [RULE_14] With internal ECC the device overwrites spare-area parity bytes.
// [RULE_15] Without internal ECC the spare area is stored as loaded.
// [RULE_16] Quad loads 32h and 34h move data on all four lines.
// [RULE_17] Write protect enable set makes the device reject quad instructions.
// [RULE_18] Program execute is 10h then a 24-bit page address.
// [RULE_19] Pages in a block are programmed in ascending order only; host checks the order only within the last programmed block.
// [RULE_20] Device programs self-timed with busy, then clears busy and latch.
// [RULE_21] Program into a protected block is not executed.
// [RULE_22] Program execute must stay on the plane of the buffered page.
// [RULE_23] Write enable is the single opcode 06h framed by chip select.
// [RULE_24] Status reads 0Fh or 05h work anytime, including while busy.
// [RULE_25] While busy the device ignores erase, load and program execute.
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module nps_host #(
    parameter int SCK_HALF = 4,
    parameter int PLANE_SEL = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic flash_cs_n,
    output logic flash_sclk,
    output logic [3:0] flash_io_o,
    output logic [3:0] flash_io_oe,
    input wire logic [3:0] flash_io_i
);
    import nps_pkg::*;

    nps_state_t state_q, state_d, ret_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q, wdata_q;
    logic [7:0] awaddr_q;
    logic [3:0] wstrb_q;
    logic [2:0] job_q, cfg_q;
    logic [23:0] addr_q;
    logic [7:0] dat_q, sr_q;
    logic dat_last_q, dat_full_q, cur_last_q;
    logic cs_n_q, issued_q, wen_done_q, done_q, refused_q;
    logic [1:0] byte_idx_q;
    logic [3:0] gap_q;
    logic [11:0] cnt_q;
    logic [17:0] last_blk_q;
    logic [5:0] last_pg_q;
    logic last_vld_q;
    logic sh_busy, sh_done;
    logic [7:0] sh_rx;
    logic [31:0] wmask;

    // Register bus decode
    wire aw_hs = s_axi_awvalid && awready_q;
    wire w_hs = s_axi_wvalid && wready_q;
    wire wr_fire = !awready_q && !wready_q && !bvalid_q;
    wire ar_hs = s_axi_arvalid && arready_q;
    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign wmask[8*i+7:8*i] = {8{wstrb_q[i]}};
    end
    wire [31:0] wval = wdata_q & wmask;
    wire sel_ctrl = awaddr_q == REG_CTRL;
    wire sel_cfg = awaddr_q == REG_CFG;
    wire sel_addr = awaddr_q == REG_ADDR;
    wire sel_data = awaddr_q == REG_DATA;
    wire wr_hit = sel_ctrl || sel_cfg || sel_addr || sel_data || awaddr_q == REG_STAT;
    wire wr_data = wr_fire && sel_data && wstrb_q[0];
    wire start_req = wr_fire && sel_ctrl && wval[CTRL_START_BIT];
    wire [2:0] req_job = wval[2:0];
    wire req_quad = req_job == JOB_QLOAD || req_job == JOB_QRLOAD;
    wire req_valid = req_job >= JOB_ERASE && req_job <= JOB_PROG;

    // Host-side admission checks
    wire [17:0] blk = addr_q[23:PAGE_BITS];
    wire [5:0] pg = addr_q[PAGE_BITS-1:0];
    wire order_ok = !last_vld_q || blk != last_blk_q || pg > last_pg_q; // [RULE_19]
    wire plane_ok = !cfg_q[CFG_PCHK_BIT] || addr_q[PLANE_SEL] == cfg_q[CFG_PLANE_BIT]; // [RULE_22]
    wire quad_ok = !(req_quad && cfg_q[CFG_WPE_BIT]); // [RULE_17]
    wire prog_ok = req_job != JOB_PROG || (order_ok && plane_ok);
    wire start_ok = start_req && state_q == ST_IDLE && req_valid && quad_ok && prog_ok;

    // Frame contents
    wire is_load = job_q >= JOB_LOAD && job_q <= JOB_QRLOAD;
    wire is_quad = job_q == JOB_QLOAD || job_q == JOB_QRLOAD;
    wire [7:0] opc = job_q == JOB_ERASE ? OP_ERASE : // [RULE_03]
        job_q == JOB_LOAD ? OP_LOAD : job_q == JOB_RLOAD ? OP_RLOAD : // [RULE_09]
        job_q == JOB_QLOAD ? OP_QLOAD : job_q == JOB_QRLOAD ? OP_QRLOAD : OP_PEXEC; // [RULE_18]
    wire [15:0] col = {4'h0, addr_q[COL_BITS-1:0]}; // [RULE_10]
    wire [7:0] adr_load = byte_idx_q == 2'h0 ? col[15:8] : col[7:0];
    wire [7:0] adr_page = byte_idx_q == 2'h0 ? addr_q[23:16] :
        byte_idx_q == 2'h1 ? addr_q[15:8] : addr_q[7:0];
    wire last_adr = byte_idx_q == (is_load ? 2'h1 : 2'h2);
    wire [7:0] tx_byte = state_q == ST_WEN ? OP_WREN : state_q == ST_OPC ? opc : // [RULE_23]
        state_q == ST_ADR ? (is_load ? adr_load : adr_page) :
        state_q == ST_DAT ? dat_q : state_q == ST_POLL ? OP_RDSR :
        state_q == ST_PADR ? SR3_ADDR : DUMMY_BYTE;
    wire cmd_state = state_q == ST_WEN || state_q == ST_OPC || state_q == ST_ADR ||
        state_q == ST_POLL || state_q == ST_PADR || state_q == ST_PRD;
    wire go_dat = state_q == ST_DAT && dat_full_q && !issued_q;
    wire sh_go = (cmd_state && !issued_q) || go_dat;
    wire sh_quad = state_q == ST_DAT && is_quad; // [RULE_16]
    wire dat_end = cur_last_q || cnt_q == 12'(BUF_BYTES - 1); // [RULE_08]
    wire gap_end = gap_q == 4'(CS_HIGH_CYC - 1);
    wire dev_busy = sh_rx[BUSY_BIT];
    wire frame_d = state_d != ST_IDLE && state_d != ST_GAP;
    wire fin = state_q != ST_IDLE && state_d == ST_IDLE;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (start_ok) state_d = ST_WEN; // [RULE_02]
            ST_WEN: if (sh_done) state_d = ST_GAP;
            ST_GAP: if (gap_end) state_d = ret_q;
            ST_OPC: if (sh_done) state_d = ST_ADR;
            ST_ADR: if (sh_done && last_adr) state_d = is_load ? ST_DAT : ST_GAP; // [RULE_04]
            ST_DAT: if (sh_done && dat_end) state_d = ST_IDLE; // [RULE_11]
            ST_POLL: if (sh_done) state_d = ST_PADR;
            ST_PADR: if (sh_done) state_d = ST_PRD;
            ST_PRD: if (sh_done) state_d = dev_busy ? ST_GAP : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            ret_q <= ST_IDLE;
            cs_n_q <= 1'b1;
            gap_q <= 4'h0;
        end else begin
            state_q <= state_d;
            cs_n_q <= !frame_d; // [RULE_04]
            gap_q <= state_q == ST_GAP ? gap_q + 4'h1 : 4'h0;
            if (state_d == ST_GAP && state_q != ST_GAP) begin
                ret_q <= state_q == ST_WEN ? ST_OPC : ST_POLL;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            issued_q <= 1'b0;
            wen_done_q <= 1'b0;
            byte_idx_q <= 2'h0;
            cnt_q <= 12'h000;
            cur_last_q <= 1'b0;
            sr_q <= 8'h00;
        end else begin
            issued_q <= sh_go || (issued_q && !sh_done);
            if (state_q == ST_WEN && sh_done) wen_done_q <= 1'b1; // [RULE_02]
            else if (state_q == ST_OPC && sh_done) wen_done_q <= 1'b0;
            byte_idx_q <= state_q != ST_ADR ? 2'h0 : byte_idx_q + 2'(sh_done);
            cnt_q <= state_q != ST_DAT ? 12'h000 : cnt_q + 12'(sh_done);
            if (go_dat) cur_last_q <= dat_last_q;
            if (state_q == ST_PRD && sh_done) sr_q <= sh_rx;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            job_q <= 3'h0;
            cfg_q <= 3'h0;
            addr_q <= 24'h000000;
            dat_q <= 8'h00;
            dat_last_q <= 1'b0;
            dat_full_q <= 1'b0;
            done_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            if (start_ok) job_q <= req_job;
            if (wr_fire && sel_cfg) cfg_q <= (cfg_q & ~wmask[2:0]) | wval[2:0];
            if (wr_fire && sel_addr && state_q == ST_IDLE) begin
                addr_q <= (addr_q & ~wmask[23:0]) | wval[23:0];
            end
            if (wr_data) begin
                dat_q <= wval[7:0];
                dat_last_q <= wval[DATA_LAST_BIT];
            end
            dat_full_q <= wr_data || (dat_full_q && !go_dat);
            done_q <= fin || (done_q && !start_ok);
            refused_q <= (start_req && !start_ok) || (refused_q && !start_ok);
        end
    end

    // Ascending-page tracking for the last programmed block only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_vld_q <= 1'b0;
            last_blk_q <= 18'h00000;
            last_pg_q <= 6'h00;
        end else if (state_q == ST_PRD && fin) begin
            if (job_q == JOB_PROG) begin
                last_vld_q <= 1'b1; // [RULE_19]
                last_blk_q <= blk;
                last_pg_q <= pg;
            end else if (blk == last_blk_q) begin
                last_vld_q <= 1'b0;
            end
        end
    end

    // Register bus slave
    wire [31:0] stat_word = {16'h0000, sr_q, 4'h0, done_q, refused_q,
        state_q == ST_DAT && !dat_full_q, state_q != ST_IDLE};
    wire rd_hit = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_CFG ||
        s_axi_araddr == REG_ADDR || s_axi_araddr == REG_DATA || s_axi_araddr == REG_STAT;
    wire [31:0] rd_word = s_axi_araddr == REG_CTRL ? {29'h0, job_q} :
        s_axi_araddr == REG_CFG ? {29'h0, cfg_q} :
        s_axi_araddr == REG_ADDR ? {8'h00, addr_q} :
        s_axi_araddr == REG_DATA ? {23'h0, dat_full_q, dat_q} :
        s_axi_araddr == REG_STAT ? stat_word : 32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_hs) begin
                awready_q <= 1'b0;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    nps_shift #(.HALF(SCK_HALF)) u_shift (
        .aclk(aclk),
        .aresetn(aresetn),
        .go(sh_go),
        .quad(sh_quad),
        .tx(tx_byte),
        .io_i(flash_io_i),
        .sclk(flash_sclk),
        .io_o(flash_io_o),
        .io_oe(flash_io_oe),
        .busy(sh_busy),
        .done(sh_done),
        .rx(sh_rx)
    );

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign flash_cs_n = cs_n_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_wren_first: assert property ($rose(state_q == ST_OPC) // [RULE_02]
        |-> wen_done_q && cs_n_q == 1'b0) else $error("opcode frame without write enable");
    chk_erase_code: assert property (sh_go && state_q == ST_OPC && job_q == JOB_ERASE // [RULE_03]
        |-> tx_byte == OP_ERASE) else $error("wrong erase opcode");
    chk_cs_release: assert property (sh_done && state_q == ST_ADR && last_adr // [RULE_04]
        && !is_load |=> cs_n_q ##1 cs_n_q) else $error("chip select not raised after address");
    chk_col_upper: assert property (sh_go && state_q == ST_ADR && is_load // [RULE_10]
        && byte_idx_q == 2'h0 |-> tx_byte[7:4] == 4'h0) else $error("column high nibble not zero");
    chk_load_cs_low: assert property (state_q == ST_DAT && !sh_busy |-> !cs_n_q) // [RULE_11]
        else $error("chip select high during load");
    chk_byte_cap: assert property (state_q == ST_DAT |-> cnt_q < 12'(BUF_BYTES)) // [RULE_08]
        else $error("load exceeds buffer size");
    chk_quad_wpe: assert property (start_req && req_quad && cfg_q[CFG_WPE_BIT] // [RULE_17]
        |=> refused_q && !$past(start_ok)) else $error("quad load sent under protect");
    chk_prog_order: assert property ($rose(state_q == ST_WEN) && job_q == JOB_PROG // [RULE_19]
        |-> $past(order_ok)) else $error("page programmed out of order");
    chk_plane_keep: assert property ($rose(state_q == ST_WEN) && job_q == JOB_PROG // [RULE_22]
        |-> $past(plane_ok)) else $error("program crosses plane");
    chk_poll_follow: assert property (sh_done && state_q == ST_ADR && last_adr // [RULE_18]
        && !is_load |=> state_q == ST_GAP ##[1:16] state_q == ST_POLL)
        else $error("no busy poll after execute");

    cov_erase_done: cover property (state_q == ST_PRD && fin && job_q == JOB_ERASE);
    cov_quad_load: cover property (state_q == ST_DAT && fin && is_quad);
    cov_prog_done: cover property (state_q == ST_PRD && fin && job_q == JOB_PROG);
    cov_refused: cover property (start_req && !start_ok);
endmodule

// file: hdl/nps_pkg.sv
// Constants and types shared by the NAND program/erase host controller
package nps_pkg;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_ERASE = 8'hD8;
    localparam logic [7:0] OP_LOAD = 8'h02;
    localparam logic [7:0] OP_RLOAD = 8'h84;
    localparam logic [7:0] OP_QLOAD = 8'h32;
    localparam logic [7:0] OP_QRLOAD = 8'h34;
    localparam logic [7:0] OP_PEXEC = 8'h10;
    localparam logic [7:0] OP_RDSR = 8'h0F;
    localparam logic [7:0] SR3_ADDR = 8'hC0;
    localparam logic [7:0] DUMMY_BYTE = 8'hFF;
    localparam int BUSY_BIT = 0;
    localparam logic [2:0] JOB_ERASE = 3'h1;
    localparam logic [2:0] JOB_LOAD = 3'h2;
    localparam logic [2:0] JOB_RLOAD = 3'h3;
    localparam logic [2:0] JOB_QLOAD = 3'h4;
    localparam logic [2:0] JOB_QRLOAD = 3'h5;
    localparam logic [2:0] JOB_PROG = 3'h6;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam int CTRL_START_BIT = 8;
    localparam int CFG_WPE_BIT = 0;
    localparam int CFG_PCHK_BIT = 1;
    localparam int CFG_PLANE_BIT = 2;
    localparam int DATA_LAST_BIT = 8;
    localparam int STAT_SR_LSB = 8;
    localparam int PAGE_BITS = 6;
    localparam int COL_BITS = 12;
    localparam int BUF_BYTES = 2176;
    localparam int CLK_NS = 4;
    localparam int CS_HIGH_NS = 20;
    localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [3:0] {
        ST_IDLE, ST_WEN, ST_GAP, ST_OPC, ST_ADR, ST_DAT, ST_POLL, ST_PADR, ST_PRD
    } nps_state_t;
endpackage

// file: hdl/nps_shift.sv
// Byte shifter that drives the serial clock and the four IO lines
`timescale 1ns/1ps
module nps_shift #(
    parameter int HALF = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic quad,
    input wire logic [7:0] tx,
    input wire logic [3:0] io_i,
    output logic sclk,
    output logic [3:0] io_o,
    output logic [3:0] io_oe,
    output logic busy,
    output logic done,
    output logic [7:0] rx
);
    logic [7:0] div_q;
    logic sclk_q, busy_q, done_q, quad_q, din_q;
    logic [7:0] sh_q, rx_q;
    logic [3:0] left_q, io_q, oe_q;
    logic [2:0] sync_q;
    wire tick = busy_q && (div_q == 8'(HALF - 1));
    wire fall = tick && sclk_q;
    wire last = (left_q == 4'h1);
    wire [7:0] sh_nx = quad_q ? {sh_q[3:0], 4'h0} : {sh_q[6:0], 1'b0};
    wire [3:0] io_nx = quad_q ? sh_nx[7:4] : {3'b110, sh_nx[7]};
    wire [3:0] io_ld = quad ? tx[7:4] : {3'b110, tx[7]};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_q <= 3'h0;
            din_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], io_i[1]};
            if (sync_q[1] == sync_q[2]) begin
                din_q <= sync_q[2];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 8'h00;
            sclk_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            quad_q <= 1'b0;
            sh_q <= 8'h00;
            rx_q <= 8'h00;
            left_q <= 4'h0;
            io_q <= 4'hD;
            oe_q <= 4'hD;
        end else begin
            done_q <= 1'b0;
            if (go && !busy_q) begin
                busy_q <= 1'b1;
                quad_q <= quad;
                sh_q <= tx;
                left_q <= quad ? 4'h2 : 4'h8;
                div_q <= 8'h00;
                io_q <= io_ld;
                oe_q <= quad ? 4'hF : 4'hD; // Quad data on all four lines [RULE_16]
            end else if (busy_q) begin
                div_q <= tick ? 8'h00 : div_q + 8'h01;
                if (tick) begin
                    sclk_q <= !sclk_q;
                end
                if (fall) begin
                    rx_q <= {rx_q[6:0], din_q};
                    left_q <= left_q - 4'h1;
                    sh_q <= sh_nx;
                    if (last) begin
                        busy_q <= 1'b0;
                        done_q <= 1'b1;
                    end else begin
                        io_q <= io_nx;
                    end
                end
            end
        end
    end

    assign sclk = sclk_q;
    assign io_o = io_q;
    assign io_oe = oe_q;
    assign busy = busy_q;
    assign done = done_q;
    assign rx = rx_q;

    chk_sclk_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        done_q |-> !sclk_q && !busy_q) else $error("clock not low at byte end");
endmodule

// file: verif/nps_flash_model.sv
// Behavioural serial NAND device as seen from the host controller
`timescale 1ns/1ps
module nps_flash_model (
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic [3:0] io,
    output logic so_line
);
    import nps_pkg::*;
    logic [7:0] op = 8'h00, sh = 8'h00, st = 8'h00, f_op = 8'h00;
    logic [31:0] hist = 32'h0, f_hist = 32'h0;
    logic write_enable_latch = 1'b0, busy = 1'b0;
    int nb = 0, nbit = 0, f_nb = 0, n_exec = 0, n_load = 0;
    logic [7:0] pbuf [BUF_BYTES];
    int col = 0;
    // Pages whose top address byte is FFh sit in the locked region
    wire prot = hist[23:16] == 8'hFF;
    wire qop = op == OP_QLOAD || op == OP_QRLOAD;
    wire ld = qop || op == OP_LOAD || op == OP_RLOAD;
    wire quad = qop && nb >= 3;
    initial so_line = 1'b0;
    always @(negedge cs_n) begin
        nb = 0;
        nbit = 0;
    end
    // Bits are taken on rising clock edges, MSB first
    always @(posedge sclk) begin
        if (!cs_n) begin
            sh = quad ? {sh[3:0], io} : {sh[6:0], io[0]};
            nbit = nbit + (quad ? 4 : 1);
            if (nbit == 8) begin
                nbit = 0;
                if (nb == 0) op = sh;
                hist = {hist[23:0], sh};
                nb = nb + 1;
                if (nb == 2 && op == OP_RDSR) st = {6'h00, write_enable_latch, busy};
                if (ld && write_enable_latch && nb == 3) begin
                    col = int'(hist[11:0]);
                    if (op == OP_LOAD || op == OP_QLOAD) begin
                        foreach (pbuf[i]) pbuf[i] = 8'hFF;
                    end
                end
                // Internal ECC is off here, so spare bytes keep what was loaded
                if (ld && write_enable_latch && nb >= 4) begin
                    if (col < BUF_BYTES) pbuf[col] = sh;
                    col = col + 1;
                end
            end
        end
    end
    // Status bits leave after falling edges
    always @(negedge sclk) begin
        if (!cs_n && op == OP_RDSR && nb >= 2) begin
            so_line <= st[7];
            st <= {st[6:0], 1'b0};
        end
    end
    always @(posedge cs_n) begin
        so_line <= ~so_line;
        if (op != OP_RDSR) begin
            f_op = op;
            f_hist = hist;
            f_nb = nb;
        end
        if (op == OP_WREN && nb == 1 && nbit == 0) write_enable_latch = 1'b1;
        if (ld && nb >= 4 && write_enable_latch && !busy) n_load = n_load + 1;
        if ((op == OP_ERASE || op == OP_PEXEC) && nb == 4 && nbit == 0 && write_enable_latch
            && !busy && !prot) begin
            n_exec = n_exec + 1;
            busy = 1'b1;
            fork
                begin
                    #3000;
                    busy = 1'b0;
                    write_enable_latch = 1'b0;
                end
            join_none
        end
    end
endmodule

// file: verif/tb_top.sv
// Testbench for the NAND program/erase host controller
`timescale 1ns/1ps
module tb_top;
    import nps_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic flash_cs_n, flash_sclk, so_line;
    logic [3:0] flash_io_o, flash_io_oe, line;
    int n_errors = 0, compares = 0, cyc = 0, ne = 0;
    logic [2:0] jobs [4] = '{JOB_LOAD, JOB_RLOAD, JOB_QLOAD, JOB_QRLOAD};
    logic [7:0] ops [4] = '{OP_LOAD, OP_RLOAD, OP_QLOAD, OP_QRLOAD};
    assign line = (flash_io_o & flash_io_oe) | (~flash_io_oe & {2'b11, so_line, 1'b1});
    nps_host dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .flash_cs_n(flash_cs_n),
        .flash_sclk(flash_sclk), .flash_io_o(flash_io_o), .flash_io_oe(flash_io_oe),
        .flash_io_i(line)
    );
    nps_flash_model u_dev (.cs_n(flash_cs_n), .sclk(flash_sclk), .io(line), .so_line(so_line));
    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_errors++;
            test_done;
        end
    end
    task test_done;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axr(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, RESP_OKAY}, "read response");
        s_axi_rready <= 1'b0;
    endtask
    task job(input logic [2:0] j, input logic [23:0] a, output logic [31:0] st);
        logic [1:0] r;
        axw(REG_ADDR, {8'h00, a}, r);
        axw(REG_CTRL, {23'h0, 1'b1, 5'h00, j}, r);
        do begin
            axr(REG_STAT, st);
        end while (!(st[3] || st[2]));
    endtask
    task t_erase;
        logic [31:0] st;
        job(JOB_ERASE, 24'h000140, st);
        ne++;
        chk(st & 32'h0000FF0F, 32'h8, "erase status");
        chk({u_dev.f_op, u_dev.f_hist[23:0]}, {OP_ERASE, 24'h000140}, "erase frame");
        chk(32'(u_dev.f_nb), 32'd4, "erase length");
        chk(32'(u_dev.n_exec), 32'(ne), "erase run");
        chk({31'h0, u_dev.write_enable_latch}, 32'h0, "erase latch");
        job(JOB_ERASE, 24'hFFFFC0, st);
        chk(32'(u_dev.n_exec), 32'(ne), "locked erase");
        $display("test erase finished");
    endtask
    task t_load;
        logic [31:0] st;
        logic [1:0] r;
        for (int k = 0; k < 4; k++) begin
            axw(REG_DATA, {23'h0, 1'b1, 8'h5A + 8'(k)}, r);
            job(jobs[k], 24'h00F123, st);
            chk({u_dev.f_op, u_dev.f_hist[23:0]}, {ops[k], 16'h0123, 8'h5A + 8'(k)},
                "load");
            chk({24'h0, u_dev.pbuf[12'h123]}, {24'h0, 8'h5A + 8'(k)}, "buffer byte");
            chk(32'(u_dev.n_load), 32'(k + 1), "load count");
        end
        $display("test load finished");
    endtask
    task t_prog;
        logic [31:0] st;
        job(JOB_PROG, 24'h000141, st);
        ne++;
        chk({u_dev.f_op, u_dev.f_hist[23:0]}, {OP_PEXEC, 24'h000141}, "program frame");
        chk(st & 32'h0000FF0F, 32'h8, "program status");
        chk({31'h0, u_dev.write_enable_latch}, 32'h0, "program latch");
        job(JOB_PROG, 24'h000140, st);
        chk(st & 32'h4, 32'h4, "order refused");
        chk(32'(u_dev.n_exec), 32'(ne), "order run");
        $display("test program finished");
    endtask
    task t_guard;
        logic [31:0] st;
        logic [31:0] d;
        logic [1:0] r;
        axw(REG_CFG, 32'h1, r);
        axr(REG_CFG, d);
        chk(d & 32'h7, 32'h1, "config readback");
        job(JOB_QLOAD, 24'h000010, st);
        chk(32'(u_dev.n_load), 32'd4, "quad refused");
        axw(REG_CFG, 32'h2, r);
        job(JOB_PROG, 24'h000240, st);
        chk(st & 32'h4, 32'h4, "plane refused");
        chk(32'(u_dev.n_exec), 32'(ne), "plane run");
        axw(8'h20, 32'h0, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped");
        axr(REG_CTRL, d);
        chk(d & 32'h7, {29'h0, JOB_PROG}, "last job");
        $display("test guard finished");
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_erase;
        t_load;
        t_prog;
        t_guard;
        test_done;
    end
endmodule
